// file: data_move_pkg.sv
// constants, types and encodings for the data-move execution block
// assumes a 16-bit instruction word and a 4096-byte data space
package data_move_pkg;
  // quarter phases of an instruction cycle, one-hot
  typedef enum logic [3:0] {
    Q1 = 4'h1,
    Q2 = 4'h2,
    Q3 = 4'h4,
    Q4 = 4'h8
  } quarter_e;

  // instruction classes handled here
  typedef enum logic [6:0] {
    OP_NONE  = 7'h01,
    OP_IOR   = 7'h02,
    OP_LPTR  = 7'h04,
    OP_COPY_FILE_REG  = 7'h08,
    OP_COPY_FILE_TO_FILE = 7'h10,
    OP_LBANK = 7'h20,
    OP_EXT   = 7'h40
  } op_e;

  // opcode prefixes and masks
  localparam logic [15:0] IOR_MASK    = 16'hFC00;
  localparam logic [15:0] IOR_CODE    = 16'h1000;
  localparam logic [15:0] COPY_FILE_REG_MASK   = 16'hFC00;
  localparam logic [15:0] COPY_FILE_REG_CODE   = 16'h5000;
  localparam logic [15:0] LPTR_MASK   = 16'hFFC0;
  localparam logic [15:0] LPTR_CODE   = 16'hEE00;
  localparam logic [15:0] LBANK_MASK  = 16'hFF00;
  localparam logic [15:0] LBANK_CODE  = 16'h0100;
  localparam logic [3:0]  FF_SRC_PFX  = 4'hC;
  localparam logic [3:0]  EXT_PFX     = 4'hF;

  // field positions inside the instruction word
  localparam int D_BIT     = 9;
  localparam int A_BIT     = 8;
  localparam int PTR_LSB   = 4;
  localparam int HIGH_NIB  = 3;

  // addressing constants
  localparam logic [7:0]  INDEX_LIMIT = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam logic [11:0] ACC_ADDR    = 12'hFE8;
  localparam logic [11:0] PCL_ADDR    = 12'hFF9;
  localparam logic [11:0] STACK_TOP_LOW_ADDR   = 12'hFFD;
  localparam logic [11:0] STACK_TOP_HIGH_ADDR   = 12'hFFE;
  localparam logic [11:0] STACK_TOP_UPPER_ADDR   = 12'hFFF;

  // reset values and pointer count
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [7:0]  BANK_RST  = 8'h00;
  localparam logic [11:0] PTR_RST   = 12'h000;
  localparam int          PTR_COUNT = 3;
endpackage : data_move_pkg

// file: quarter_if.sv
// quarter-phase and decode bundle shared between the core's modules
// assumes one clock; all members are driven on clk
`timescale 1ns/1ps
`default_nettype none
interface quarter_if;
  data_move_pkg::quarter_e q;
  logic                    cycle_start;
  data_move_pkg::op_e      op;
  modport source (output q, output cycle_start, input op);
  modport sink   (input q, input cycle_start, output op);
endinterface : quarter_if
`default_nettype wire

// file: quarter_gen.sv
// quarter-phase sequencer: Q1..Q4 ring, one quarter per clock
// assumes rst clears the ring to Q1
`timescale 1ns/1ps
`default_nettype none
module quarter_gen (
  input  wire logic clk,
  input  wire logic rst,
  quarter_if.source qb
);
  typedef struct packed {
    data_move_pkg::quarter_e q;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // advance one quarter each clock
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.q)
      data_move_pkg::Q1: st_next.q = data_move_pkg::Q2;
      data_move_pkg::Q2: st_next.q = data_move_pkg::Q3;
      data_move_pkg::Q3: st_next.q = data_move_pkg::Q4;
      data_move_pkg::Q4: st_next.q = data_move_pkg::Q1;
      default:           st_next.q = data_move_pkg::Q1;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg.q <= data_move_pkg::Q1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign qb.q           = st_reg.q;
  assign qb.cycle_start = (st_reg.q == data_move_pkg::Q1);
endmodule : quarter_gen
`default_nettype wire

// file: op_decode.sv
// instruction classifier for the data-move group
// assumes second words are flagged by the executor through ext_pending
`timescale 1ns/1ps
`default_nettype none
module op_decode (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] instr,
  input  wire logic        ext_pending,
  quarter_if.sink          qb
);
  typedef struct packed {
    data_move_pkg::op_e op;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // classify one word
  function automatic data_move_pkg::op_e classify(input logic [15:0] w, input logic ext);
    if (ext)
      classify = data_move_pkg::OP_EXT;  // [RL14]
    else if ((w & data_move_pkg::IOR_MASK) == data_move_pkg::IOR_CODE)
      classify = data_move_pkg::OP_IOR;
    else if ((w & data_move_pkg::COPY_FILE_REG_MASK) == data_move_pkg::COPY_FILE_REG_CODE)
      classify = data_move_pkg::OP_COPY_FILE_REG;  // [RL5]
    else if ((w & data_move_pkg::LPTR_MASK) == data_move_pkg::LPTR_CODE)
      classify = data_move_pkg::OP_LPTR;
    else if (w[15:12] == data_move_pkg::FF_SRC_PFX)
      classify = data_move_pkg::OP_COPY_FILE_TO_FILE;  // [RL9]
    else if ((w & data_move_pkg::LBANK_MASK) == data_move_pkg::LBANK_CODE)
      classify = data_move_pkg::OP_LBANK;  // [RL13]
    else
      classify = data_move_pkg::OP_NONE;
  endfunction : classify

  // latch class at decode quarter
  always_comb begin
    st_next = st_reg;
    if (qb.q == data_move_pkg::Q1) begin
      st_next.op = classify(instr, ext_pending);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg.op <= data_move_pkg::OP_NONE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign qb.op = st_reg.op;
endmodule : op_decode
`default_nettype wire

// file: data_move_exec.sv
// execution of the data-move instruction group inside an 8-bit core
// assumes a combinational data read port and a data memory write strobe set in Q4 and asserted in the quarter after Q4
//
// Function
// RL1: with access bit clear and extended set on, operands up to 5Fh are indexed offsets.
// RL2: the OR-with-file instruction runs in one cycle: decode, read, process, write.
// RL3: load-pointer-literal puts a 12-bit literal into pointer 0..2 with flags untouched.
// RL4: load-pointer-literal takes two cycles, high part first, low byte second.
// RL5: copy-file-reg moves the file byte to its destination and sets only N and Z.
// RL6: copy-file-reg writes to the accumulator for d=0 and back to the file for d=1.
// RL7: access bit 0 resolves in the access bank, 1 uses the bank-select register.
// RL8: the copy-file-reg operand reaches any byte of the chosen 256-byte bank.
// RL9: file-to-file copy is two words, prefixes 1100 and 1111, 12-bit addresses each.
// RL10: file-to-file copy accepts the accumulator location as source or destination.
// RL11: file-to-file copy never writes program counter low or the stack top bytes.
// RL12: file-to-file copy reads in cycle one, writes in Q4 of cycle two, flags untouched.
// RL13: load-bank-literal loads the bank register in Q4 with the upper nibble forced to zero.
// RL14: the second word of a two-word instruction is only an operand extension.
`timescale 1ns/1ps
`default_nettype none
module data_move_exec #(
  parameter int PTR_NUM = data_move_pkg::PTR_COUNT
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] instr,
  input  wire logic        ext_set_en,
  input  wire logic [7:0]  index_base,
  input  wire logic [7:0]  mem_rdata,
  output logic      [11:0] mem_raddr,
  output logic      [11:0] mem_waddr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_we,
  output logic      [7:0]  acc,
  output logic      [7:0]  bank_select_reg,
  output logic      [11:0] pointer0,
  output logic      [11:0] pointer1,
  output logic      [11:0] pointer2,
  output logic             flag_n,
  output logic             flag_z,
  output logic             q1_out,
  output logic             ext_busy
);
  // refuse any pointer count other than three
  if (PTR_NUM != 3) begin : g_ptr_check
    $error("data_move_exec serves exactly three pointers");
  end

  quarter_if qb ();

  // state of the executor
  typedef struct packed {
    logic [7:0]             acc;
    logic [7:0]             bank;
    logic [PTR_NUM-1:0][11:0] ptr;
    logic                   n;
    logic                   z;
    logic                   ext;       // next word is an extension
    data_move_pkg::op_e     first_op;  // owner of the pending extension
    logic [1:0]             ptr_sel;
    logic [15:0]            word;      // word under execution
    logic [7:0]             result;
    logic [11:0]            raddr;
    logic [11:0]            waddr;
    logic [7:0]             wdata;
    logic                   we;
    logic                   q1;
  } state_s;

  state_s st_reg;
  state_s st_next;

  data_move_pkg::op_e cur_op;

  quarter_gen u_quarter (
    .clk (clk),
    .rst (rst),
    .qb  (qb.source)
  );

  op_decode u_decode (
    .clk         (clk),
    .rst         (rst),
    .instr       (instr),
    .ext_pending (st_reg.ext),
    .qb          (qb.sink)
  );

  assign cur_op = qb.op;

  // resolve an 8-bit file operand to a 12-bit address
  function automatic logic [11:0] file_addr(
    input logic [7:0] f,
    input logic       a,
    input logic [7:0] bank,
    input logic       ext_en,
    input logic [7:0] base
  );
    logic [7:0] sum;
    sum = 8'h00;
    if (a) begin
      file_addr = {bank[3:0], f};  // [RL7] [RL8]
    end else if (ext_en && (f <= data_move_pkg::INDEX_LIMIT)) begin
      sum = base + f;
      file_addr = {4'h0, sum};  // [RL1]
    end else if (f < data_move_pkg::ACCESS_SPLIT) begin
      file_addr = {4'h0, f};  // [RL7]
    end else begin
      file_addr = {data_move_pkg::ACCESS_HI_BANK, f};
    end
  endfunction : file_addr

  // destinations that file-to-file copy must not touch
  function automatic logic protected_dest(input logic [11:0] ad);
    protected_dest = (ad == data_move_pkg::PCL_ADDR) || (ad == data_move_pkg::STACK_TOP_LOW_ADDR)
                  || (ad == data_move_pkg::STACK_TOP_HIGH_ADDR) || (ad == data_move_pkg::STACK_TOP_UPPER_ADDR);
  endfunction : protected_dest

  // per-quarter execution
  always_comb begin
    logic [11:0] fa;
    logic [7:0]  rd;
    st_next = st_reg;
    fa = file_addr(st_reg.word[7:0], st_reg.word[data_move_pkg::A_BIT], st_reg.bank,
                   ext_set_en, index_base);
    // accumulator lives here, not in data memory
    rd = (st_reg.raddr == data_move_pkg::ACC_ADDR) ? st_reg.acc : mem_rdata;  // [RL10]
    st_next.we = 1'b0;
    st_next.q1 = (qb.q == data_move_pkg::Q4);
    unique case (qb.q)
      data_move_pkg::Q1: begin
        st_next.word = instr;  // decode
      end
      data_move_pkg::Q2: begin
        unique case (cur_op)
          data_move_pkg::OP_IOR, data_move_pkg::OP_COPY_FILE_REG: begin
            st_next.raddr = fa;  // [RL2] [RL5]
          end
          data_move_pkg::OP_COPY_FILE_TO_FILE: begin
            st_next.raddr = st_reg.word[11:0];  // [RL9] [RL10]
          end
          default: ;  // no dummy read on extension words [RL12]
        endcase
      end
      data_move_pkg::Q3: begin
        unique case (cur_op)
          data_move_pkg::OP_IOR: st_next.result = rd | st_reg.acc;  // [RL2]
          data_move_pkg::OP_COPY_FILE_REG: st_next.result = rd;  // [RL5]
          data_move_pkg::OP_COPY_FILE_TO_FILE: st_next.result = rd;  // [RL12] [RL10]
          default: ;
        endcase
      end
      data_move_pkg::Q4: begin
        unique case (cur_op)
          data_move_pkg::OP_IOR, data_move_pkg::OP_COPY_FILE_REG: begin
            st_next.n = st_reg.result[7];  // [RL5]
            st_next.z = (st_reg.result == 8'h00);  // [RL5]
            if (st_reg.word[data_move_pkg::D_BIT]) begin
              if (fa == data_move_pkg::ACC_ADDR) begin
                st_next.acc = st_reg.result;  // [RL6]
              end else begin
                st_next.waddr = fa;  // [RL6]
                st_next.wdata = st_reg.result;
                st_next.we    = 1'b1;  // [RL2]
              end
            end else begin
              st_next.acc = st_reg.result;  // [RL6]
            end
          end
          data_move_pkg::OP_LPTR: begin
            st_next.ptr_sel = st_reg.word[data_move_pkg::PTR_LSB +: 2];
            if (st_next.ptr_sel < PTR_NUM[1:0]) begin
              st_next.ptr[st_next.ptr_sel][11:8] =
                st_reg.word[data_move_pkg::HIGH_NIB:0];  // [RL3] [RL4]
            end
            st_next.ext      = 1'b1;
            st_next.first_op = data_move_pkg::OP_LPTR;
          end
          data_move_pkg::OP_COPY_FILE_TO_FILE: begin
            st_next.ext      = 1'b1;  // [RL9]
            st_next.first_op = data_move_pkg::OP_COPY_FILE_TO_FILE;
          end
          data_move_pkg::OP_LBANK: begin
            st_next.bank = {4'h0, st_reg.word[3:0]};  // [RL13]
          end
          data_move_pkg::OP_EXT: begin
            st_next.ext = 1'b0;  // [RL14]
            if (st_reg.first_op == data_move_pkg::OP_LPTR) begin
              if (st_reg.ptr_sel < PTR_NUM[1:0]) begin
                st_next.ptr[st_reg.ptr_sel][7:0] = st_reg.word[7:0];  // [RL4]
              end
            end else if (st_reg.word[15:12] == data_move_pkg::EXT_PFX) begin
              if (st_reg.word[11:0] == data_move_pkg::ACC_ADDR) begin
                st_next.acc = st_reg.result;  // [RL10]
              end else if (!protected_dest(st_reg.word[11:0])) begin  // [RL11]
                st_next.waddr = st_reg.word[11:0];  // [RL12]
                st_next.wdata = st_reg.result;
                st_next.we    = 1'b1;
              end
            end
          end
          default: ;
        endcase
      end
      default: ;
    endcase
  end

  // register all state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg.acc      <= data_move_pkg::ACC_RST;
      st_reg.bank     <= data_move_pkg::BANK_RST;
      st_reg.ptr      <= '0;
      st_reg.n        <= 1'b0;
      st_reg.z        <= 1'b0;
      st_reg.ext      <= 1'b0;
      st_reg.first_op <= data_move_pkg::OP_NONE;
      st_reg.ptr_sel  <= 2'h0;
      st_reg.word     <= 16'h0000;
      st_reg.result   <= 8'h00;
      st_reg.raddr    <= 12'h000;
      st_reg.waddr    <= 12'h000;
      st_reg.wdata    <= 8'h00;
      st_reg.we       <= 1'b0;
      st_reg.q1       <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from state
  assign acc             = st_reg.acc;
  assign bank_select_reg = st_reg.bank;
  assign pointer0        = st_reg.ptr[0];
  assign pointer1        = st_reg.ptr[1];
  assign pointer2        = st_reg.ptr[2];
  assign flag_n          = st_reg.n;
  assign flag_z          = st_reg.z;
  assign mem_raddr       = st_reg.raddr;
  assign mem_waddr       = st_reg.waddr;
  assign mem_wdata       = st_reg.wdata;
  assign mem_we          = st_reg.we;
  assign q1_out          = st_reg.q1;
  assign ext_busy        = st_reg.ext;
endmodule : data_move_exec
`default_nettype wire

// file: data_move_exec_chk.sv
// concurrent checks on the data-move executor's ports
// assumes one clock domain and an async active-high reset
`timescale 1ns/1ps
`default_nettype none
module data_move_exec_chk #(
  parameter int PTR_NUM = 3
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [15:0] instr,
  input wire logic        mem_we,
  input wire logic [11:0] mem_waddr,
  input wire logic [7:0]  acc,
  input wire logic [7:0]  bank_select_reg,
  input wire logic [11:0] pointer0,
  input wire logic [11:0] pointer1,
  input wire logic [11:0] pointer2,
  input wire logic        flag_n,
  input wire logic        flag_z,
  input wire logic        q1_out
);
  logic [15:0] word_reg;
  logic [15:0] prev_reg;
  logic        lone;
  // current and previous word, taken at the end of each Q1
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_reg <= 16'h0000;
      prev_reg <= 16'h0000;
    end else if (q1_out) begin
      word_reg <= instr;
      prev_reg <= word_reg;
    end
  end
  // word is not the tail of a two-word pair
  assign lone = prev_reg[15:12] != 4'hC && prev_reg[15:8] != 8'hEE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // first edge that sees Q1, results of the finished word are in place
  sequence q1_entry_s;
    $rose(q1_out);
  endsequence
  // write strobe after a file-to-file pair
  sequence ff_tail_s;
    mem_we && word_reg[15:12] == 4'hF && prev_reg[15:12] == 4'hC;
  endsequence
  AST_Q1_RING: assert property (q1_entry_s |=> !q1_out [*3] ##1 q1_out)
    else $error("quarter ring out of step");
  AST_WE_PULSE: assert property (mem_we |=> !mem_we)
    else $error("write strobe longer than one clock");
  AST_WE_IN_Q1: assert property (mem_we |-> q1_out)
    else $error("write strobe outside the quarter after Q4");
  AST_ACC_AT_Q4: assert property ($changed(acc) |-> q1_out)
    else $error("accumulator changed off the Q4 write");
  AST_BANK_NIBBLE: assert property (bank_select_reg[7:4] == 4'h0)
    else $error("bank select upper nibble set");
  AST_LBANK_LOAD: assert property (q1_entry_s ##0 (word_reg[15:8] == 8'h01 && lone)
    |-> bank_select_reg == {4'h0, word_reg[3:0]})
    else $error("bank select not loaded from literal");
  AST_LPTR_LOAD: assert property (q1_entry_s ##0 prev_reg[15:8] == 8'hEE
    |-> (prev_reg[5:4] == 2'd0 ? pointer0 : prev_reg[5:4] == 2'd1 ? pointer1 : pointer2)
    == {prev_reg[3:0], word_reg[7:0]})
    else $error("pointer not loaded with literal");
  AST_COPY_FILE_REG_FLAGS: assert property (q1_entry_s ##0 (word_reg[15:9] == 7'h28 && lone)
    |-> flag_z == (acc == 8'h00) && flag_n == acc[7])
    else $error("flags do not follow moved byte");
  AST_FF_DEST: assert property (ff_tail_s |-> mem_waddr == word_reg[11:0])
    else $error("copy wrote the wrong address");
  AST_FF_GUARD: assert property (ff_tail_s |->
    !(mem_waddr inside {12'hFF9, 12'hFFD, 12'hFFE, 12'hFFF}))
    else $error("copy wrote a protected location");
endmodule : data_move_exec_chk
bind data_move_exec data_move_exec_chk #(.PTR_NUM(PTR_NUM)) chk (.clk(clk), .rst(rst),
  .instr(instr), .mem_we(mem_we), .mem_waddr(mem_waddr), .acc(acc),
  .bank_select_reg(bank_select_reg), .pointer0(pointer0), .pointer1(pointer1),
  .pointer2(pointer2), .flag_n(flag_n), .flag_z(flag_z), .q1_out(q1_out));
`default_nettype wire

// file: data_move_exec_test.sv
// self-checking bench for the data-move executor
// assumes the package, the design and its checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module data_move_exec_test;
  logic        clk;
  logic        rst;
  logic [15:0] instr;
  logic        ext_set_en;
  logic [7:0]  index_base;
  logic [7:0]  mem_rdata;
  logic [11:0] mem_raddr;
  logic [11:0] mem_waddr;
  logic [7:0]  mem_wdata;
  logic        mem_we;
  logic [7:0]  acc;
  logic [7:0]  bank_select_reg;
  logic [11:0] pointer0;
  logic [11:0] pointer1;
  logic [11:0] pointer2;
  logic        flag_n;
  logic        flag_z;
  logic        q1_out;
  logic        ext_busy;
  logic [7:0]  mem [4096];
  logic        ext_v;
  logic [7:0]  base_v;
  logic [11:0] wr_addr;
  logic [7:0]  wr_data;
  int          wr_count;
  int          fail_count;
  int          checks;

  data_move_exec dut (.clk(clk), .rst(rst), .instr(instr), .ext_set_en(ext_set_en),
    .index_base(index_base), .mem_rdata(mem_rdata), .mem_raddr(mem_raddr),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .mem_we(mem_we), .acc(acc),
    .bank_select_reg(bank_select_reg), .pointer0(pointer0), .pointer1(pointer1),
    .pointer2(pointer2), .flag_n(flag_n), .flag_z(flag_z), .q1_out(q1_out),
    .ext_busy(ext_busy));

  // 200 MHz clock
  always #2.5 clk = ~clk;
  // data memory: combinational read, write on the strobe
  assign mem_rdata = mem[mem_raddr];
  always @(posedge clk) begin
    if (mem_we === 1'b1) begin
      mem[mem_waddr] <= mem_wdata;
      wr_addr <= mem_waddr;
      wr_data <= mem_wdata;
      wr_count <= wr_count + 1;
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test

  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  function automatic logic [11:0] ptr(input int p);
    return (p == 0) ? pointer0 : (p == 1) ? pointer1 : pointer2;
  endfunction : ptr

  // one word per four clocks, entered and left mid Q4
  task automatic issue(input logic [15:0] w);
    @(posedge clk) begin
      instr <= w;
      ext_set_en <= ext_v;
      index_base <= base_v;
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : issue

  // word followed by an idle word so its results and write have landed
  task automatic run(input logic [15:0] w);
    issue(w);
    issue(16'h0000);
  endtask : run

  task automatic ff(input logic [11:0] s, input logic [11:0] d);
    issue({4'hC, s});
    issue({4'hF, d});
    issue(16'h0000);
  endtask : ff

  // align to the quarter ring after reset
  task automatic sync;
    int i;
    i = 0;
    while (q1_out !== 1'b0 && i < 8) begin
      @(negedge clk);
      i++;
    end
    while (q1_out !== 1'b1 && i < 16) begin
      @(negedge clk);
      i++;
    end
    if (i >= 16) begin
      fail_count++;
      end_of_test;
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : sync

  task automatic t_lbank;
    run(16'h01A5);
    cmp(12'(bank_select_reg), 12'h005);
    run(16'h0103);
    cmp(12'(bank_select_reg), 12'h003);
    $display("lbank done");
  endtask : t_lbank

  task automatic t_copy_file_reg;
    int n;
    mem[12'h022] = 8'h00;
    mem[12'hF80] = 8'h80;
    mem[12'h3FF] = 8'hC4;
    mem[12'h09F] = 8'h11;
    mem[12'hF60] = 8'h22;
    mem[12'h05F] = 8'h33;
    run(16'h5022);
    cmp(12'(acc), 12'h000);
    cmp(12'({flag_n, flag_z}), 12'h001);
    run(16'h5080);
    cmp(12'(acc), 12'h080);
    cmp(12'({flag_n, flag_z}), 12'h002);
    n = wr_count;
    run(16'h53FF);
    cmp(wr_addr, 12'h3FF);
    cmp(12'(wr_data), 12'h0C4);
    cmp(12'(wr_count - n), 12'h001);
    cmp(12'(acc), 12'h080);
    ext_v = 1'b1;
    base_v = 8'h40;
    run(16'h505F);
    cmp(12'(acc), 12'h011);
    run(16'h5060);
    cmp(12'(acc), 12'h022);
    ext_v = 1'b0;
    run(16'h505F);
    cmp(12'(acc), 12'h033);
    $display("copy_file_reg done");
  endtask : t_copy_file_reg

  task automatic t_lptr;
    logic [11:0] k;
    logic [7:0]  b;
    logic [1:0]  fl;
    for (int p = 0; p < 3; p++) begin
      k = (p == 0) ? 12'h3AB : (p == 1) ? 12'hFFF : 12'h5C1;
      b = bank_select_reg;
      fl = {flag_n, flag_z};
      issue({8'hEE, 2'b00, 2'(p), k[11:8]});
      issue({8'h01, k[7:0]});
      cmp(ptr(p), {k[11:8], 8'h00});
      cmp(12'(ext_busy), 12'h001);
      issue(16'h0000);
      cmp(ptr(p), k);
      cmp(12'(ext_busy), 12'h000);
      cmp(12'(bank_select_reg), 12'(b));
      cmp(12'({flag_n, flag_z}), 12'(fl));
    end
    $display("lptr done");
  endtask : t_lptr

  task automatic t_copy_file_to_file;
    int          n;
    logic [7:0]  e;
    logic [1:0]  fl;
    logic [11:0] src [3];
    logic [11:0] dst [3];
    logic [11:0] bad [4];
    src = '{12'h123, 12'h000, 12'h7FF};
    dst = '{12'h456, 12'hFFC, 12'h000};
    bad = '{12'hFF9, 12'hFFD, 12'hFFE, 12'hFFF};
    mem[12'h123] = 8'h5A;
    fl = {flag_n, flag_z};
    for (int i = 0; i < 3; i++) begin
      n = wr_count;
      e = mem[src[i]];
      ff(src[i], dst[i]);
      cmp(wr_addr, dst[i]);
      cmp(12'(wr_data), 12'(e));
      cmp(12'(wr_count - n), 12'h001);
    end
    cmp(12'({flag_n, flag_z}), 12'(fl));
    ff(12'h123, 12'hFE8);
    cmp(12'(acc), 12'h05A);
    mem[12'hFE8] = 8'hA5;
    ff(12'hFE8, 12'h200);
    cmp(wr_addr, 12'h200);
    cmp(12'(wr_data), 12'h05A);
    for (int i = 0; i < 4; i++) begin
      n = wr_count;
      ff(12'h123, bad[i]);
      cmp(12'(wr_count - n), 12'h000);
    end
    $display("copy_file_to_file done");
  endtask : t_copy_file_to_file

  task automatic t_ior;
    mem[12'h013] = 8'hA4;
    run(16'h1013);
    cmp(12'(acc), 12'h0FE);
    cmp(12'({flag_n, flag_z}), 12'h002);
    run(16'h1213);
    cmp(wr_addr, 12'h013);
    cmp(12'(wr_data), 12'h0FE);
    $display("ior done");
  endtask : t_ior

  // reset, align, then the scenarios
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    instr = 16'h0000;
    ext_set_en = 1'b0;
    index_base = 8'h00;
    ext_v = 1'b0;
    base_v = 8'h00;
    wr_addr = 12'h000;
    wr_data = 8'h00;
    wr_count = 0;
    fail_count = 0;
    checks = 0;
    for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'h5A;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    sync;
    t_lbank;
    t_copy_file_reg;
    t_lptr;
    t_copy_file_to_file;
    t_ior;
    end_of_test;
  end
endmodule : data_move_exec_test
`default_nettype wire
